// File: rtl/stack_extended_data_ram_config_register.sv
module stack_extended_data_ram_config_register (
    input wire logic clk_sys,
    input wire logic rst_b,
    // sfr bus from the core
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // stack operations from the core
    input wire logic stack_push,
    input wire logic stack_pop,
    output logic [10:0] stack_addr,
    // data access from the core
    input wire logic xdata_req,
    input wire logic [23:0] xdata_addr,
    output logic xdata_int_sel,
    output logic xdata_ext_sel,
    output logic [23:0] xdata_addr_out,
    // configuration visible to the core
    output logic extended_stack_enable,
    output logic internal_extended_data_ram_map_enable
);
    // ==================================================
    // state
    // all flops of the block sit in one packed record, so the
    // next-state logic and the register stage cannot drift apart
    typedef struct packed {
        logic ext_stack;      // cfg bit 7: extended stack on
        logic extended_data_ram_map;       // cfg bit 0: internal ram mapped
        logic [7:0] low_ptr;  // stack pointer low byte
        logic [2:0] high_ptr; // stack pointer high bits
        logic [7:0] rdata;    // read data, zero when idle
        logic hit;            // readable address matched
        logic int_sel;        // access goes to internal ram
        logic ext_sel;        // access goes to external bus
        logic [23:0] xaddr;   // routed address copy
    } state_t;

    // working signals
    state_t st_ff;         // registered state
    state_t nxt_st;        // next state, built by the comb process
    logic [10:0] step_ptr; // pointer after this cycle's push or pop
    logic pop_only;        // pop that no push masks
    logic win_low;         // address in the low 2 kbyte window

    // ==================================================
    // decode helpers
    // address compare, shared by the read and the write decode
    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] r);
        addr_is = (a == r);
    endfunction

    // read image of the config register
    // unimplemented positions always read back as zero
    function automatic logic [7:0] cfg_image(input logic ext,
                                             input logic map);
        cfg_image = 8'h00;
        cfg_image[stack_extended_data_ram_pkg::ext_stack_bit] = ext;
        cfg_image[stack_extended_data_ram_pkg::extended_data_ram_map_bit] = map;
    endfunction

    // ==================================================
    // pointer arithmetic
    // push has priority: a pop in the same cycle is dropped
    assign pop_only = stack_pop & ~stack_push;

    // one stepper serves both modes; the mode picks the carry
    // the instance only computes, the flops stay in this module
    stack_ptr_next stack_ptr_next_inst (
        .ext_en(st_ff.ext_stack),
        .inc(stack_push),
        .dec(pop_only),
        .ptr_cur({st_ff.high_ptr, st_ff.low_ptr}),
        .ptr_next(step_ptr)
    );

    // ==================================================
    // data window decode
    // the window is the lowest 2 kbytes, so it is enough that all
    // address bits above the window are zero
    // the map enable is applied in the routing, not here
    assign win_low = (xdata_addr[stack_extended_data_ram_pkg::ext_addr_bits - 1:
                                 stack_extended_data_ram_pkg::extended_data_ram_addr_bits] == '0);

    // ==================================================
    // next state
    // one process builds the whole next record; the copy at the top
    // gives every field a value on every path
    always_comb begin
        nxt_st = st_ff;
        // read answer and hit stand for one cycle only
        nxt_st.hit = 1'h0;
        nxt_st.rdata = 8'h00;

        // stack step; pre-increment means push address is new value
        // pre-increment push
        nxt_st.low_ptr = step_ptr[7:0];
        nxt_st.high_ptr = step_ptr[10:8];

        // sfr writes win over a stack step in the same cycle, so a
        // pointer reload by software is never lost
        if (sfr_wr) begin
            if (addr_is(sfr_addr, stack_extended_data_ram_pkg::cfg_addr)) begin
                nxt_st.ext_stack =
                    sfr_wdata[stack_extended_data_ram_pkg::ext_stack_bit];
                nxt_st.extended_data_ram_map =
                    sfr_wdata[stack_extended_data_ram_pkg::extended_data_ram_map_bit];
            end
            // low byte is writable in both modes
            if (addr_is(sfr_addr, stack_extended_data_ram_pkg::low_ptr_addr)) begin
                nxt_st.low_ptr = sfr_wdata;
            end
            if (addr_is(sfr_addr, stack_extended_data_ram_pkg::high_ptr_addr)
                && st_ff.ext_stack) begin
                // only the three low bits exist
                nxt_st.high_ptr = sfr_wdata[2:0];
            end
        end

        // high byte held zero
        // clearing the enable also clears the high bits, so a later
        // re-enable starts from page zero, not from a stale page
        if (!nxt_st.ext_stack) begin
            nxt_st.high_ptr = 3'h0;
        end

        // reads see the registered values, not this cycle's write
        if (sfr_rd) begin
            if (addr_is(sfr_addr, stack_extended_data_ram_pkg::cfg_addr)) begin
                nxt_st.hit = 1'h1;
                nxt_st.rdata = cfg_image(st_ff.ext_stack, st_ff.extended_data_ram_map);
            end
            // low byte readable in both modes
            if (addr_is(sfr_addr, stack_extended_data_ram_pkg::low_ptr_addr)) begin
                nxt_st.hit = 1'h1;
                nxt_st.rdata = st_ff.low_ptr;
            end
            // read gated
            // a locked high byte answers like an unmapped address
            if (addr_is(sfr_addr, stack_extended_data_ram_pkg::high_ptr_addr)
                && st_ff.ext_stack) begin
                nxt_st.hit = 1'h1;
                nxt_st.rdata = {5'h00, st_ff.high_ptr};
            end
        end

        // data routing, registered one cycle
        // the address copy follows the bus every cycle; the selects
        // pulse only for a request, so they never both stand
        nxt_st.int_sel = 1'h0;
        nxt_st.ext_sel = 1'h0;
        nxt_st.xaddr = xdata_addr;
        if (xdata_req) begin
            if (st_ff.extended_data_ram_map && win_low) begin
                nxt_st.int_sel = 1'h1;
            end else begin
                nxt_st.ext_sel = 1'h1;
            end
        end
    end

    // ==================================================
    // registers
    // synchronous reset; the config and pointer reset values are package constants, the rest load zero
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_ff.ext_stack <=
                stack_extended_data_ram_pkg::cfg_reset[stack_extended_data_ram_pkg::ext_stack_bit];
            st_ff.extended_data_ram_map <=
                stack_extended_data_ram_pkg::cfg_reset[stack_extended_data_ram_pkg::extended_data_ram_map_bit];
            st_ff.low_ptr <= stack_extended_data_ram_pkg::low_ptr_reset;
            st_ff.high_ptr <= stack_extended_data_ram_pkg::high_ptr_reset;
            // nothing is answered or routed while reset is held
            st_ff.rdata <= 8'h00;
            st_ff.hit <= 1'h0;
            st_ff.int_sel <= 1'h0;
            st_ff.ext_sel <= 1'h0;
            st_ff.xaddr <= 24'h000000;
        end else begin
            // the whole record moves at once
            st_ff <= nxt_st;
        end
    end

    // ==================================================
    // outputs, all straight from flops
    // no logic after the flops, so the core sees clean timing
    // sfr side
    assign sfr_rdata = st_ff.rdata;
    assign sfr_hit = st_ff.hit;
    // stack side
    assign stack_addr = {st_ff.high_ptr, st_ff.low_ptr};
    // data side
    assign xdata_int_sel = st_ff.int_sel;
    assign xdata_ext_sel = st_ff.ext_sel;
    assign xdata_addr_out = st_ff.xaddr;
    // config bits
    assign extended_stack_enable = st_ff.ext_stack;
    assign internal_extended_data_ram_map_enable = st_ff.extended_data_ram_map;
endmodule

// File: rtl/stack_extended_data_ram_pkg.sv
package stack_extended_data_ram_pkg;
    // ==================================================
    // sfr addresses
    localparam logic [7:0] cfg_addr = 8'haf;
    localparam logic [7:0] high_ptr_addr = 8'hb7;
    localparam logic [7:0] low_ptr_addr = 8'h81;
    // ==================================================
    // field positions and reset values
    localparam int ext_stack_bit = 7;
    localparam int extended_data_ram_map_bit = 0;
    localparam logic [7:0] cfg_reset = 8'h00;
    localparam logic [7:0] low_ptr_reset = 8'h07;
    localparam logic [2:0] high_ptr_reset = 3'h0;
    // internal ram window: lowest 2 kbytes, 11 address bits
    localparam int extended_data_ram_addr_bits = 11;
    // external data space: 16 MB, 24 address bits
    localparam int ext_addr_bits = 24;
endpackage

// File: rtl/stack_ptr_next.sv
// ==================================================
// next stack pointer for push/call (inc) and pop/ret (dec)
module stack_ptr_next (
    input wire logic ext_en,
    input wire logic inc,
    input wire logic dec,
    input wire logic [10:0] ptr_cur,
    output logic [10:0] ptr_next
);
    // carry into high bits only in extended mode
    always_comb begin
        ptr_next = ptr_cur;
        if (ext_en) begin
            if (inc)
                ptr_next = ptr_cur + 11'h001;
            else if (dec)
                ptr_next = ptr_cur - 11'h001;
        end else begin
            if (inc)
                ptr_next = {3'h0, ptr_cur[7:0] + 8'h01};
            else if (dec)
                ptr_next = {3'h0, ptr_cur[7:0] - 8'h01};
        end
    end
endmodule

// File: dv/stack_extended_data_ram_checker.sv
// ==========
// port checker: config, stack and decode timing
module stack_extended_data_ram_checker (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic stack_push,
    input wire logic [10:0] stack_addr,
    input wire logic xdata_req,
    input wire logic [23:0] xdata_addr,
    input wire logic xdata_int_sel,
    input wire logic xdata_ext_sel,
    input wire logic extended_stack_enable,
    input wire logic internal_extended_data_ram_map_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic es, low;
    assign es = extended_stack_enable;
    // internal window hit, low 2 kbytes
    assign low = internal_extended_data_ram_map_enable && xdata_addr < 24'h000800;
    chk_cfg_write: assert property (
        sfr_wr && sfr_addr == 8'haf |=> es == $past(sfr_wdata[7])
        && internal_extended_data_ram_map_enable == $past(sfr_wdata[0]))
        else $error("cfg write lost");
    chk_push_wrap: assert property (
        stack_push && !sfr_wr && !es
        |=> stack_addr == {3'h0, $past(stack_addr[7:0]) + 8'h01})
        else $error("normal push wrong");
    chk_push_carry: assert property (
        stack_push && !sfr_wr && es
        |=> stack_addr == $past(stack_addr) + 11'h001)
        else $error("extended push wrong");
    chk_int_sel: assert property (
        xdata_req && low |=> xdata_int_sel && !xdata_ext_sel)
        else $error("internal select wrong");
    chk_ext_sel: assert property (
        xdata_req && !low |=> xdata_ext_sel && !xdata_int_sel)
        else $error("external select wrong");
    chk_cfg_read: assert property (
        sfr_rd && !sfr_wr && sfr_addr == 8'haf |=> sfr_hit && sfr_rdata
        == {$past(es), 6'h00, $past(internal_extended_data_ram_map_enable)})
        else $error("cfg read wrong");
    chk_high_locked: assert property (
        sfr_rd && !sfr_wr && sfr_addr == 8'hb7 && !es
        |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("high byte readable");
    chk_idle_data: assert property (
        !sfr_rd |=> sfr_rdata == 8'h00) else $error("rdata not idle");
    cover property (stack_push && es);
    cover property (xdata_req && low);
    cover property (sfr_rd && sfr_addr == 8'hb7 && es);
endmodule
bind stack_extended_data_ram_config_register stack_extended_data_ram_checker chk_inst (
    .clk_sys, .rst_b, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata,
    .sfr_rdata, .sfr_hit, .stack_push, .stack_addr, .xdata_req,
    .xdata_addr, .xdata_int_sel, .xdata_ext_sel,
    .extended_stack_enable, .internal_extended_data_ram_map_enable);

// File: dv/core_model.sv
// ==========
// core side: one-cycle stack pulses
module core_model (
    input wire logic clk_sys,
    output logic stack_push,
    output logic stack_pop
);
    timeunit 1ns;
    timeprecision 1ps;
    initial stack_push = 1'b0;
    initial stack_pop = 1'b0;
    task push;
        @(posedge clk_sys) stack_push <= 1'b1;
        @(posedge clk_sys) stack_push <= 1'b0;
    endtask
    task pop;
        @(posedge clk_sys) stack_pop <= 1'h1;
        @(posedge clk_sys) stack_pop <= 1'h0;
    endtask
endmodule

// File: dv/stack_extended_data_ram_config_register_tb.sv
module stack_extended_data_ram_config_register_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0, rst_b = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0;
    logic req = 1'h0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rdat;
    logic [23:0] xa = 24'h0, xo;
    logic [10:0] sa;
    logic hit, push, pop, isel, esel, es, me;
    int error_cnt = 0, comparisons = 0;
    initial forever #5 clk_sys = ~clk_sys;
    stack_extended_data_ram_config_register stack_extended_data_ram_config_register_inst (
        .clk_sys, .rst_b, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata,
        .sfr_rdata(rdat), .sfr_hit(hit), .stack_push(push),
        .stack_pop(pop), .stack_addr(sa), .xdata_req(req),
        .xdata_addr(xa), .xdata_int_sel(isel), .xdata_ext_sel(esel),
        .xdata_addr_out(xo), .extended_stack_enable(es),
        .internal_extended_data_ram_map_enable(me));
    core_model core_model_inst (.clk_sys, .stack_push(push),
        .stack_pop(pop));
    task chk(string n, logic [23:0] s, logic [23:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h seen %h", n, e, s);
        end
    endtask
    task wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys) {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, a, d};
        @(posedge clk_sys) sfr_wr <= 1'b0;
    endtask
    task rd(logic [7:0] a, logic [7:0] e, logic h);
        @(posedge clk_sys) {sfr_rd, sfr_addr} <= {1'b1, a};
        @(posedge clk_sys) sfr_rd <= 1'b0;
        #1 chk("rdata", rdat, e);
        chk("hit", hit, h);
    endtask
    task pu(logic [10:0] e);
        core_model_inst.push();
        #1 chk("stack", sa, e);
    endtask
    task po(logic [10:0] e);
        core_model_inst.pop();
        #1 chk("stack", sa, e);
    endtask
    task xd(logic [23:0] a, logic i);
        @(posedge clk_sys) {req, xa} <= {1'b1, a};
        @(posedge clk_sys) req <= 1'b0;
        #1 chk("int", isel, i);
        chk("ext", esel, !i);
        chk("addr out", xo, a);
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #20000 error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1 chk("reset stack", sa, 11'h007);
        rd(8'haf, 8'h00, 1'b1);
        pu(11'h008);
        wr(8'h81, 8'hff);
        pu(11'h000);
        po(11'h0ff);
        wr(8'hb7, 8'h07);
        rd(8'hb7, 8'h00, 1'b0);
        $display("test normal stack done");
        wr(8'haf, 8'hff);
        #1 chk("cfg bits", {es, me}, 2'h3);
        rd(8'haf, 8'h81, 1'b1);
        wr(8'h81, 8'hff);
        pu(11'h100);
        po(11'h0ff);
        wr(8'hb7, 8'h05);
        rd(8'hb7, 8'h05, 1'b1);
        $display("test extended stack done");
        xd(24'h0007ff, 1'b1);
        xd(24'h000800, 1'b0);
        wr(8'haf, 8'h80);
        #1 chk("cfg bits", {es, me}, 2'h2);
        xd(24'h0007ff, 1'b0);
        $display("test data decode done");
        @(posedge clk_sys) rst_b <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'h1;
        #1 chk("reset cfg", {es, me}, 2'h0);
        chk("reset stack", sa, 11'h007);
        rd(8'haf, 8'h00, 1'h1);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule
